// *** core/lcdc_consts.svh ***
// Constants for the LCD command decoder
`ifndef LCDC_CONSTS_SVH
`define LCDC_CONSTS_SVH
`define LCDC_CONT_BIT      7
`define LCDC_SLAVE_ADDR_HI 6'h1C
`define LCDC_MODE_OP       2'h2
`define LCDC_DEVSEL_OP     4'hC
`define LCDC_BANK_OP       5'h1E
`define LCDC_BLINK_OP      4'hE
`define LCDC_PTR_LAST      6'h27
`define LCDC_SUB_MAX       3'h7
`define LCDC_DRIVE_STATIC  2'h1
`define LCDC_DRIVE_MUX2    2'h2
`define LCDC_DRIVE_MUX4    2'h0
`define LCDC_BLINK_DIV1    12'd768
`define LCDC_BLINK_DIV2    12'd1536
`define LCDC_BLINK_DIV3    12'd3072
`define LCDC_WORDS         40
`endif

// *** core/lcdc_decoder.sv ***
// LCD command decoder and display controller status logic
// What this block does
// - Bytes after slave address are sorted into commands or display data.
// - Bit 7 of a command set means the next byte is also a command.
// - After a command with bit 7 clear, all further bytes are data.
// - Bits 6:5 = 10 is mode-set; bit 3 enables display, bit 4 ignored.
// - Mode-set bit 2 picks half bias; bits 1:0 pick drive mode.
// - Bit 6 clear loads low six bits into the data pointer.
// - Bits 6:3 = 1100 loads low three bits into subaddress counter.
// - Bits 6:2 = 11110 is bank-select; bit 1 picks input bank.
// - Bank-select bit 0 picks the output bank independently.
// - Bank-select has no effect in three- or four-way multiplex.
// - Bits 6:3 = 1110 is blink-select; bit 2 alternate, bits 1:0 rate.
// - Three- and four-way multiplex behave as normal blinking.
// - No alternate bank blinking in three- or four-way multiplex.
// - Decoded commands update status registers driving the display.
// - Data bytes fill display RAM in drive-mode order.
// - Blink rates toggle at clock divided by 768, 1536, 3072.
// - Answer only slave address 0111 00x matching pin; writes only.
// - Pointer advances per data byte, subaddress when the pointer wraps; only match acks.
`timescale 1ns/1ps
`include "lcdc_consts.svh"
module lcdc_decoder
  import lcdc_pkg::*;
#(
  parameter int WORDS = `LCDC_WORDS
) (
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  input  wire logic         start_i,
  input  wire logic         stop_i,
  input  wire logic         byte_vld_i,
  input  wire logic [7:0]   byte_i,
  input  wire logic         slave_lsb_pin_i,
  input  wire logic [2:0]   hw_subaddr_i,
  input  wire logic [5:0]   disp_addr_i,
  output logic              ack_o,
  output lcdc_status_s      status_o,
  output logic              blink_phase_o,
  output logic              display_on_o,
  output logic              show_alt_o,
  output logic [3:0]        disp_data_o,
  output logic [5:0]        data_ptr_o,
  output logic [2:0]        subaddr_o
);

  // ****************************************
  // State and status registers
  // ****************************************
  lcdc_state_e  state_ff, nxt_state;
  lcdc_status_s stat_ff, nxt_stat;
  logic [5:0]   ptr_ff, nxt_ptr;
  logic [2:0]   sub_ff, nxt_sub;
  logic         ack_ff, nxt_ack;
  lcdc_ram_wr_s wr_ff, nxt_wr;
  logic [1:0]   part_ff, nxt_part;
  logic [11:0]  bcnt_ff, nxt_bcnt;
  logic         bph_ff, nxt_bph;

  // Three- and four-way multiplex have no alternate bank
  function automatic logic no_alt_bank(input logic [1:0] mode);
    no_alt_bank = (mode != `LCDC_DRIVE_STATIC) && (mode != `LCDC_DRIVE_MUX2);
  endfunction

  // Pixels per RAM word used by the given drive mode
  function automatic logic [2:0] word_bits(input logic [1:0] mode);
    if (mode == `LCDC_DRIVE_STATIC) begin
      word_bits = 3'd1;
    end else if (mode == `LCDC_DRIVE_MUX2) begin
      word_bits = 3'd2;
    end else if (mode == `LCDC_DRIVE_MUX4) begin
      word_bits = 3'd4;
    end else begin
      word_bits = 3'd3;
    end
  endfunction

  logic        sel_match;
  logic [1:0]  parts;
  logic [2:0]  bits;
  logic [11:0] div_lim;
  logic [3:0]  wmask;
  logic [3:0]  wdata;
  logic [3:0]  sbase;
  logic [2:0]  bits_left;

  assign sel_match = (sub_ff == hw_subaddr_i);
  assign bits      = word_bits(stat_ff.drive_mode);

  // ****************************************
  // Byte sorting, command decode and data fill
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_stat  = stat_ff;
    nxt_ptr   = ptr_ff;
    nxt_sub   = sub_ff;
    nxt_ack   = 1'b0;
    nxt_part  = part_ff;
    nxt_wr    = '0;
    parts     = 2'd0;
    wmask     = 4'h0;
    wdata     = 4'h0;
    sbase     = 4'h0;
    bits_left = 3'd0;
    if (start_i) begin
      nxt_state = LCDC_ADDR;
      nxt_part  = 2'd0;
    end else if (stop_i) begin
      nxt_state = LCDC_IDLE;
    end else if (byte_vld_i) begin
      case (state_ff)
        LCDC_ADDR: begin
          // Write address with matching low bit only
          if ((byte_i[7:2] == `LCDC_SLAVE_ADDR_HI) && (byte_i[1] == slave_lsb_pin_i)
              && !byte_i[0]) begin
            nxt_state = LCDC_CMD;
            nxt_ack   = 1'b1;
          end else begin
            nxt_state = LCDC_IDLE;
          end
        end
        LCDC_CMD: begin
          nxt_ack = 1'b1;
          // Continuation flag picks next byte class
          nxt_state = byte_i[`LCDC_CONT_BIT] ? LCDC_CMD : LCDC_DATA;
          // Status updates per opcode
          if (!byte_i[6]) begin
            nxt_ptr  = byte_i[5:0];
            nxt_part = 2'd0;
          end else if (byte_i[6:5] == `LCDC_MODE_OP) begin
            nxt_stat.display_en = byte_i[3];
            nxt_stat.half_bias  = byte_i[2];
            nxt_stat.drive_mode = byte_i[1:0];
          end else if (byte_i[6:3] == `LCDC_DEVSEL_OP) begin
            nxt_sub = byte_i[2:0];
          end else if (byte_i[6:3] == `LCDC_BLINK_OP) begin
            nxt_stat.alt_blink        = byte_i[2];
            nxt_stat.blink_rate_field = byte_i[1:0];
          end else if ((byte_i[6:2] == `LCDC_BANK_OP) && !byte_i[0]
                       && !no_alt_bank(stat_ff.drive_mode)) begin
            nxt_stat.in_bank  = byte_i[1];
          end else if ((byte_i[6:2] == `LCDC_BANK_OP) && byte_i[0]
                       && !no_alt_bank(stat_ff.drive_mode)) begin
            nxt_stat.in_bank  = byte_i[1];
            nxt_stat.out_bank = byte_i[0];
          end
          // Other patterns leave status alone
          if ((byte_i[6:2] == `LCDC_BANK_OP) && !byte_i[0]
              && !no_alt_bank(stat_ff.drive_mode)) begin
            nxt_stat.out_bank = 1'b0;
          end
        end
        LCDC_DATA: begin
          // Data bytes fill RAM words MSB first
          nxt_ack = sel_match;
          parts   = 2'(8 / int'(bits) - 1);
          if (bits == 3'd3) begin
            parts = 2'd2;
          end
          bits_left = bits;
          sbase     = (stat_ff.in_bank && !no_alt_bank(stat_ff.drive_mode)) ? 4'd2 : 4'd0;
          for (int k = 0; k < 4; k++) begin
            if (k < int'(part_ff) + 1 && k >= int'(part_ff)) begin
              for (int b = 0; b < 4; b++) begin
                if (b < int'(bits_left)) begin
                  wmask[b + int'(sbase)] = 1'b1;
                  wdata[b + int'(sbase)] = byte_i[7 - (k * int'(bits) + b)];
                end
              end
            end
          end
          nxt_wr = '0;
          if (sel_match) begin
            nxt_wr.we   = 1'b1;
            nxt_wr.addr = ptr_ff;
            nxt_wr.mask = wmask;
            nxt_wr.data = wdata;
          end
          // One word per byte here; pointer advances per data byte, stored or not
          if (ptr_ff == `LCDC_PTR_LAST) begin
            nxt_ptr = 6'h0;
            nxt_sub = sub_ff + 3'd1;
          end else begin
            nxt_ptr = ptr_ff + 6'd1;
          end
          nxt_part = 2'd0;
        end
        default: begin
          nxt_state = LCDC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_ff <= LCDC_IDLE;
      stat_ff  <= '0;
      ptr_ff   <= 6'h0;
      sub_ff   <= 3'h0;
      ack_ff   <= 1'b0;
      wr_ff    <= '0;
      part_ff  <= 2'd0;
    end else begin
      state_ff <= nxt_state;
      stat_ff  <= nxt_stat;
      ptr_ff   <= nxt_ptr;
      sub_ff   <= nxt_sub;
      ack_ff   <= nxt_ack;
      wr_ff    <= nxt_wr;
      part_ff  <= nxt_part;
    end
  end

  // ****************************************
  // Blink divider
  // ****************************************
  always_comb begin
    if (stat_ff.blink_rate_field == 2'd1) begin
      div_lim = `LCDC_BLINK_DIV1;
    end else if (stat_ff.blink_rate_field == 2'd2) begin
      div_lim = `LCDC_BLINK_DIV2;
    end else begin
      div_lim = `LCDC_BLINK_DIV3;
    end
    nxt_bcnt = bcnt_ff + 12'd1;
    nxt_bph  = bph_ff;
    if (stat_ff.blink_rate_field == 2'd0) begin
      nxt_bcnt = 12'd0;
      nxt_bph  = 1'b0;
    end else if (bcnt_ff >= div_lim - 12'd1) begin
      nxt_bcnt = 12'd0;
      nxt_bph  = ~bph_ff;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bcnt_ff <= 12'd0;
      bph_ff  <= 1'b0;
    end else begin
      bcnt_ff <= nxt_bcnt;
      bph_ff  <= nxt_bph;
    end
  end

  // ****************************************
  // Display side outputs
  // ****************************************
  logic alt_eff;
  logic blink_act;
  assign alt_eff = stat_ff.alt_blink && !no_alt_bank(stat_ff.drive_mode);
  // Stale phase is masked in the cycle blinking is switched off
  assign blink_act = bph_ff && (stat_ff.blink_rate_field != 2'd0);

  assign display_on_o  = stat_ff.display_en && !(blink_act && !alt_eff);
  assign show_alt_o    = alt_eff ? (stat_ff.out_bank ^ blink_act)
                                 : (stat_ff.out_bank && !no_alt_bank(stat_ff.drive_mode));
  assign ack_o         = ack_ff;
  assign status_o      = stat_ff;
  assign blink_phase_o = bph_ff;
  assign data_ptr_o    = ptr_ff;
  assign subaddr_o     = sub_ff;

  lcdc_ram #(
    .WORDS (WORDS)
  ) u_ram (
    .sys_clk_i (sys_clk_i),
    .wr_i      (wr_ff),
    .rd_addr_i (disp_addr_i),
    .rd_data_o (disp_data_o)
  );
endmodule

// *** core/lcdc_pkg.sv ***
// Types for the LCD command decoder
package lcdc_pkg;
  typedef enum logic [1:0] {
    LCDC_IDLE = 2'b00,
    LCDC_ADDR = 2'b01,
    LCDC_CMD  = 2'b10,
    LCDC_DATA = 2'b11
  } lcdc_state_e;

  typedef struct packed {
    logic       display_en;
    logic       half_bias;
    logic [1:0] drive_mode;
    logic       in_bank;
    logic       out_bank;
    logic       alt_blink;
    logic [1:0] blink_rate_field;
  } lcdc_status_s;

  typedef struct packed {
    logic       we;
    logic [5:0] addr;
    logic [3:0] mask;
    logic [3:0] data;
  } lcdc_ram_wr_s;
endpackage

// *** core/lcdc_ram.sv ***
// Display RAM of 4-bit words with masked write and registered read
`timescale 1ns/1ps
module lcdc_ram
  import lcdc_pkg::*;
#(
  parameter int WORDS = 40
) (
  input  wire logic         sys_clk_i,
  input  wire lcdc_ram_wr_s wr_i,
  input  wire logic [5:0]   rd_addr_i,
  output logic      [3:0]   rd_data_o
);
  logic [3:0] mem [WORDS];

  // Masked write and registered read
  always_ff @(posedge sys_clk_i) begin
    if (wr_i.we && (int'(wr_i.addr) < WORDS)) begin
      mem[wr_i.addr] <= (mem[wr_i.addr] & ~wr_i.mask) | (wr_i.data & wr_i.mask);
    end
    rd_data_o <= (int'(rd_addr_i) < WORDS) ? mem[rd_addr_i] : 4'h0;
  end
endmodule

// *** verification/lcdc_decoder_monitor.sv ***
// Port-level checker for the LCD command decoder
`timescale 1ns/1ps
// *****
// Checker
// *****
module lcdc_decoder_monitor
  import lcdc_pkg::*;
(
  input wire logic         sys_clk_i,
  input wire logic         srst_i,
  input wire logic         start_i,
  input wire logic         stop_i,
  input wire logic         byte_vld_i,
  input wire logic [7:0]   byte_i,
  input wire logic         slave_lsb_pin_i,
  input wire logic         ack_o,
  input wire lcdc_status_s status_o,
  input wire logic         blink_phase_o,
  input wire logic         display_on_o,
  input wire logic         show_alt_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  logic        want_ff;
  logic        nxt_want;
  logic        phase_ff;
  logic        armed_ff;
  logic        nxt_armed;
  logic [1:0]  rate_ff;
  logic [11:0] gap_ff;
  logic [11:0] nxt_gap;
  logic        toggled;
  logic [11:0] div;
  // Address expected next, blink gap since last toggle
  always_comb begin
    nxt_want  = start_i | (want_ff & ~byte_vld_i & ~stop_i);
    toggled   = blink_phase_o != phase_ff;
    nxt_gap   = toggled ? 12'h001 : gap_ff + 12'h001;
    nxt_armed = (status_o.blink_rate_field == rate_ff) && (armed_ff || toggled);
    div       = 12'h300 << (rate_ff - 2'h1); // Gap was run at the previous rate
  end
  // Helper registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      want_ff  <= 1'b0;
      phase_ff <= 1'b0;
      armed_ff <= 1'b0;
      rate_ff  <= 2'h0;
      gap_ff   <= 12'h000;
    end else begin
      want_ff  <= nxt_want;
      phase_ff <= blink_phase_o;
      armed_ff <= nxt_armed;
      rate_ff  <= status_o.blink_rate_field;
      gap_ff   <= nxt_gap;
    end
  end
  a_ack_cause: assert property (ack_o |-> $past(byte_vld_i))
    else $error("ack without a byte");
  a_addr_match: assert property (want_ff && byte_vld_i && !start_i && !stop_i
    && byte_i == {6'h1C, slave_lsb_pin_i, 1'b0} |=> ack_o) else $error("own address not acked");
  a_addr_reject: assert property (want_ff && byte_vld_i && !start_i && !stop_i
    && byte_i != {6'h1C, slave_lsb_pin_i, 1'b0} |=> !ack_o) else $error("foreign address acked");
  a_status_cause: assert property ($changed(status_o) |-> $past(byte_vld_i))
    else $error("status changed without a byte");
  a_bank_locked: assert property ($past(status_o.drive_mode[1]) ==
    $past(status_o.drive_mode[0]) |-> $stable({status_o.in_bank, status_o.out_bank}))
    else $error("bank moved in three or four way mode");
  a_alt_gone: assert property (show_alt_o |->
    status_o.drive_mode[1] != status_o.drive_mode[0]) else $error("alternate bank in mux3/4");
  a_blank_off: assert property (!status_o.display_en |-> !display_on_o)
    else $error("display on while blanked");
  a_blink_off: assert property (status_o.blink_rate_field == 2'h0 |->
    display_on_o == status_o.display_en) else $error("blinking while off");
  a_blink_gap: assert property (armed_ff && toggled |-> gap_ff == div)
    else $error("blink toggle interval wrong");
  c_ack: cover property (ack_o);
  c_gap: cover property (armed_ff && toggled);
  c_alt: cover property (show_alt_o);
endmodule
bind lcdc_decoder lcdc_decoder_monitor i_mon (.sys_clk_i, .srst_i, .start_i, .stop_i,
  .byte_vld_i, .byte_i, .slave_lsb_pin_i, .ack_o, .status_o, .blink_phase_o,
  .display_on_o, .show_alt_o);

// *** verification/lcdc_master_model.sv ***
// Behavioural bus master feeding whole transfers to the decoder
`timescale 1ns/1ps
// *****
// Master
// *****
module lcdc_master_model (
  input  wire logic  sys_clk_i,
  input  wire logic  ack_i,
  output logic       start_o,
  output logic       stop_o,
  output logic       vld_o,
  output logic [7:0] byte_o,
  output logic [15:0] acks_o
);
  // Idle bus at time zero
  initial begin
    start_o = 1'b0;
    stop_o  = 1'b0;
    vld_o   = 1'b0;
    byte_o  = 8'hA5;
    acks_o  = 16'h0000;
  end
  // One byte; ack looked at once settled
  task automatic put(input logic [7:0] b);
    @(posedge sys_clk_i) begin
      vld_o  <= 1'b1;
      byte_o <= b;
    end
    @(posedge sys_clk_i) begin
      vld_o  <= 1'b0;
      byte_o <= ~b; // Released line shows the inverse
    end
    #1 acks_o = {acks_o[14:0], ack_i};
  endtask
  // Start, address, commands, data, stop
  task automatic xfer(input logic [7:0] q[$]);
    acks_o = 16'h0000;
    @(posedge sys_clk_i) start_o <= 1'b1;
    @(posedge sys_clk_i) start_o <= 1'b0;
    foreach (q[i]) put(q[i]);
    @(posedge sys_clk_i) stop_o <= 1'b1;
    @(posedge sys_clk_i) stop_o <= 1'b0;
  endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the LCD command decoder
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
// *****
// Bench
// *****
module tb_top
  import lcdc_pkg::*;
;
  logic         clk;
  logic         srst;
  logic         lsb;
  logic [2:0]   hw_sub;
  logic         ack;
  logic         start;
  logic         stop;
  logic         vld;
  logic [7:0]   byt;
  lcdc_status_s st;
  logic         phase;
  logic         on;
  logic         alt;
  logic [5:0]   ptr;
  logic [2:0]   sub;
  logic [5:0]   daddr;
  logic [3:0]   dd;
  int           fails;
  int           n_compared;
  int           cycles;
  int           n;
  lcdc_decoder i_dut (.sys_clk_i(clk), .srst_i(srst), .start_i(start), .stop_i(stop),
    .byte_vld_i(vld), .byte_i(byt), .slave_lsb_pin_i(lsb), .hw_subaddr_i(hw_sub),
    .disp_addr_i(daddr), .ack_o(ack), .status_o(st), .blink_phase_o(phase),
    .display_on_o(on), .show_alt_o(alt), .disp_data_o(dd), .data_ptr_o(ptr), .subaddr_o(sub));
  lcdc_master_model i_mst (.sys_clk_i(clk), .ack_i(ack), .start_o(start), .stop_o(stop),
    .vld_o(vld), .byte_o(byt), .acks_o());
  // Clock of 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Transfer and compare the acknowledge pattern
  task automatic send(input logic [7:0] q[$], input logic [15:0] exp_acks);
    i_mst.xfer(q);
    `CHK("acks", exp_acks, i_mst.acks_o)
  endtask
  // Cycles until the blink phase moves
  task automatic gap(output int k);
    logic p;
    p = phase;
    k = 0;
    while (phase === p && k < 4000) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask
  // Counts and verdict
  task automatic print_verdict();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      print_verdict();
    end
  end
  // Test sequence
  initial begin
    srst   = 1'b1;
    lsb    = 1'b0;
    hw_sub = 3'h0;
    daddr  = 6'h00;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("status", 9'h000, st)
    send('{8'h72, 8'h4F}, 16'h0000);
    send('{8'h71, 8'h4F}, 16'h0000);
    `CHK("status", 9'h000, st)
    for (int i = 0; i < 4; i++) begin
      send('{8'h70, {4'hD, i[0], i[1], 2'(i + 2)}, 8'h05}, 16'h0007);
      `CHK("mode", {i[0], i[1], 2'(i + 2)}, st[8:5])
    end
    `CHK("ptr", 6'h05, ptr)
    send('{8'h70, 8'h7A}, 16'h0003);
    `CHK("banks", 3'h4, {st.in_bank, st.out_bank, alt})
    send('{8'h70, 8'h79}, 16'h0003);
    `CHK("banks", 3'h3, {st.in_bank, st.out_bank, alt})
    send('{8'h70, 8'hC8, 8'h7A}, 16'h0007);
    `CHK("banks", 3'h2, {st.in_bank, st.out_bank, alt})
    send('{8'h70, 8'hFC, 8'h49, 8'h4A}, 16'h000F);
    `CHK("status", 9'h128, st)
    `CHK("ptr", 6'h06, ptr)
    @(posedge clk) hw_sub <= 3'h3;
    send('{8'h70, 8'hA7, 8'h63, 8'h55, 8'h4A}, 16'h001E);
    `CHK("ptr sub", {6'h01, 3'h4}, {ptr, sub})
    `CHK("drive", 2'h1, st.drive_mode)
    send('{8'h70, 8'hE3, 8'hFA, 8'h0A, 8'h80}, 16'h001F);
    `CHK("ptr", 6'h0B, ptr)
    @(posedge clk) daddr <= 6'h0A;
    @(posedge clk);
    #1;
    `CHK("ram bit", 1'b1, dd[2])
    for (int r = 1; r < 4; r++) begin
      send('{8'h70, 8'(8'h70 + r)}, 16'h0003);
      `CHK("rate", 2'(r), st.blink_rate_field)
      gap(n);
      gap(n);
      `CHK("gap", 768 << (r - 1), n)
    end
    send('{8'h70, 8'h75}, 16'h0003);
    `CHK("alt blink", 1'b1, st.alt_blink)
    send('{8'h70, 8'h48}, 16'h0003);
    gap(n);
    gap(n);
    `CHK("gap", 768, n)
    `CHK("alt", 1'b0, alt)
    send('{8'h70, 8'h70}, 16'h0003);
    `CHK("on", 1'b1, on)
    print_verdict();
  end
endmodule
